/* File: design/eccf_framer.sv */
/*
  Parser of explicit-addressing command frames from the host serial stream,
  with APB registers and a buffered command record output.
  Assumes host bytes arrive from logic on the same clock; APB master as usual.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eccf_framer #(
  parameter logic [7:0] MAX_HOPS_DEFAULT = eccf_pkg::MAXHOPS_RST
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        rxByte,
  input  wire logic              rxValid,
  output logic                   rxReady,
  output logic                   cmdValid,
  input  wire logic              cmdReady,
  output eccf_pkg::eccf_cmd_t    cmd,
  output logic                   txStatusValid,
  output logic [7:0]             txStatusId,
  output logic                   explicitRxMode
);

  typedef struct packed {
    eccf_pkg::eccf_phase_t phase;
    logic [15:0]           idx;
    logic [15:0]           len;
    logic [7:0]            sum;
    logic                  drop;
    eccf_pkg::eccf_cmd_t   rec;
    logic                  ctrlEn;
    logic                  ctrlRxo;
    logic [7:0]            maxHops;
    eccf_pkg::eccf_err_t   status;
    logic [15:0]           accCount;
    logic [15:0]           dropCount;
    logic [31:0]           last;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  rxReady;
    logic                  txStatusValid;
    logic [7:0]            txStatusId;
  } eccf_st_t;

  eccf_st_t st_q;
  eccf_st_t st_d;
  logic     bufInReady;

  localparam int ATTRW = $clog2(eccf_pkg::ATTR_MAX);

  function automatic logic csumOk(input logic [7:0] sum, input logic [7:0] b);
    csumOk = (8'(eccf_pkg::CSUM_BASE - sum) == b);
  endfunction : csumOk

  function automatic logic [15:0] shiftIn(input logic [15:0] v, input logic [7:0] b);
    shiftIn = {v[7:0], b};
  endfunction : shiftIn

  function automatic logic regHit(input logic [11:0] a);
    regHit = (a == eccf_pkg::REG_CTRL) || (a == eccf_pkg::REG_STATUS) ||
             (a == eccf_pkg::REG_COUNT) || (a == eccf_pkg::REG_LAST);
  endfunction : regHit

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic                      take;
    logic                      wrDone;
    logic [7:0]                b;
    logic [15:0]               i;
    logic [15:0]               pay;
    logic [15:0]               payLen;
    logic                      mfr;
    logic [ATTRW:0]            slot;
    eccf_pkg::eccf_err_t       errSet;
    eccf_pkg::eccf_err_t       errClr;
    take    = '0;
    wrDone  = '0;
    b       = rxByte;
    i       = st_q.idx;
    pay     = '0;
    payLen  = '0;
    mfr     = st_q.rec.frameCtrl[eccf_pkg::FC_MFR_BIT];
    slot    = '0;
    errSet  = '0;
    errClr  = '0;
    st_d    = st_q;
    st_d.txStatusValid = 1'b0;
    take    = rxValid && st_q.rxReady;

    // Host stream parsing
    if (take) begin
      st_d.idx = 16'(st_q.idx + 16'h0001);
      if (!st_q.phase[4] && !st_q.phase[0] && !st_q.phase[1] && !st_q.phase[3]) begin
        st_d.sum = 8'(st_q.sum + b);
      end
      unique case (st_q.phase)
        eccf_pkg::P_HUNT: begin
          if (b == eccf_pkg::DELIM) begin
            st_d.phase = eccf_pkg::P_LEN;
            st_d.idx   = 16'h0001;
            st_d.sum   = '0;
            st_d.drop  = 1'b0;
            st_d.rec   = '0;
          end
        end
        eccf_pkg::P_LEN: begin
          st_d.len = shiftIn(st_q.len, b);
          if (i == eccf_pkg::OFF_LEN_LSB) begin
            if (shiftIn(st_q.len, b) < eccf_pkg::MIN_LEN) begin
              errSet.shortLen = 1'b1;
              st_d.phase      = eccf_pkg::P_HUNT;
              st_d.dropCount  = 16'(st_q.dropCount + 16'h0001);
            end else begin
              st_d.phase = eccf_pkg::P_BODY;
            end
          end
        end
        eccf_pkg::P_BODY: begin
          if (i == eccf_pkg::OFF_FTYPE && b != eccf_pkg::FT_EXPLICIT) begin
            errSet.badType = 1'b1;
            st_d.drop      = 1'b1;
          end
          if (i == eccf_pkg::OFF_FID) begin
            st_d.rec.frameId = b;
          end
          if (i >= eccf_pkg::OFF_ADDR64 && i <= eccf_pkg::OFF_ADDR64_LS) begin
            st_d.rec.dest64 = {st_q.rec.dest64[55:0], b};
          end
          if (i >= eccf_pkg::OFF_ADDR16 && i <= eccf_pkg::OFF_ADDR16_LS) begin
            st_d.rec.dest16 = shiftIn(st_q.rec.dest16, b);
          end
          if (i == eccf_pkg::OFF_SRCEP) begin
            st_d.rec.srcEp = b;
          end
          if (i == eccf_pkg::OFF_DSTEP) begin
            st_d.rec.dstEp = b;
          end
          if (i == eccf_pkg::OFF_CLUSTER || i == 16'(eccf_pkg::OFF_CLUSTER + 16'h0001)) begin
            st_d.rec.clusterId = shiftIn(st_q.rec.clusterId, b);
          end
          if (i == eccf_pkg::OFF_PROFILE || i == 16'(eccf_pkg::OFF_PROFILE + 16'h0001)) begin
            st_d.rec.profileId = shiftIn(st_q.rec.profileId, b);
          end
          if (i == eccf_pkg::OFF_RADIUS) begin
            st_d.rec.radius = (b == 8'h00) ? st_q.maxHops : b;
          end
          if (i == eccf_pkg::OFF_TXOPT && b != 8'h00) begin
            errSet.txOptNz = 1'b1;
          end
          if (i == eccf_pkg::OFF_FCTRL) begin
            st_d.rec.frameCtrl = b;
            if (b[7:eccf_pkg::FC_RSVD_LSB] != 3'h0) begin
              errSet.rsvdNz = 1'b1;
            end
          end
          if (i == eccf_pkg::OFF_SEQ) begin
            st_d.rec.seqNum = b;
          end
          if (i == eccf_pkg::OFF_CMDID) begin
            st_d.rec.cmdId    = b;
            st_d.rec.readAttr = (st_q.rec.frameCtrl[eccf_pkg::FC_TYPE_LSB +: 2] == eccf_pkg::FTYPE_GENERAL) &&
                                (b == eccf_pkg::CMD_READ_ATTR);
          end
          if (i >= eccf_pkg::OFF_PAYLOAD) begin
            pay = 16'(i - eccf_pkg::OFF_PAYLOAD);
            if (mfr && pay < 16'h0002) begin
              // Manufacturer code present only when flagged
              if (pay[0]) begin
                st_d.rec.mfrCode[15:8] = b;
              end else begin
                st_d.rec.mfrCode[7:0] = b;
              end
            end else begin
              if (mfr) begin
                pay = 16'(pay - 16'h0002);
              end
              slot = pay[ATTRW+1:1];
              if (pay[15:ATTRW+2] != '0 || int'(slot) >= eccf_pkg::ATTR_MAX) begin
                errSet.attrOvf = 1'b1;
              end else if (!pay[0]) begin
                st_d.rec.attrs[slot[ATTRW-1:0]][7:0] = b;
              end else begin
                st_d.rec.attrs[slot[ATTRW-1:0]][15:8] = b;
                st_d.rec.attrCount = eccf_pkg::ATTR_CNT_W'(st_q.rec.attrCount + 1'b1);
              end
            end
          end
          if (i == 16'(st_q.len + eccf_pkg::LEN_BIAS)) begin
            st_d.phase = eccf_pkg::P_CSUM;
          end
        end
        eccf_pkg::P_CSUM: begin
          payLen = 16'(st_q.len - eccf_pkg::MIN_LEN - (mfr ? 16'h0002 : 16'h0000));
          if (payLen[0]) begin
            errSet.oddPay = 1'b1;
          end
          st_d.rec.broadcast = (st_q.rec.dest64 == eccf_pkg::BCAST64) ||
                               (st_q.rec.dest16 == eccf_pkg::BCAST16);
          if (!csumOk(st_q.sum, b)) begin
            errSet.csumBad = 1'b1;
          end
          if (st_q.drop || !csumOk(st_q.sum, b)) begin
            st_d.phase     = eccf_pkg::P_HUNT;
            st_d.dropCount = 16'(st_q.dropCount + 16'h0001);
          end else begin
            st_d.phase = eccf_pkg::P_EMIT;
            st_d.last  = {st_q.rec.frameCtrl, st_q.rec.cmdId, st_q.rec.seqNum, st_q.rec.frameId};
          end
        end
        eccf_pkg::P_EMIT: begin
        end
      endcase
    end

    // Hand the record to the buffer; stall the host until it is taken
    if (st_q.phase == eccf_pkg::P_EMIT && bufInReady) begin
      st_d.phase         = eccf_pkg::P_HUNT;
      st_d.accCount      = 16'(st_q.accCount + 16'h0001);
      st_d.txStatusValid = (st_q.rec.frameId != 8'h00);
      st_d.txStatusId    = st_q.rec.frameId;
    end

    // APB slave: one answer cycle after setup
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    if (psel && !penable) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = !regHit(paddr);
      st_d.prdata  = '0;
      if (!pwrite) begin
        unique case (paddr)
          eccf_pkg::REG_CTRL:   st_d.prdata = {16'h0000, st_q.maxHops, 6'h00, st_q.ctrlRxo, st_q.ctrlEn};
          eccf_pkg::REG_STATUS: st_d.prdata = {25'h0000000, st_q.status};
          eccf_pkg::REG_COUNT:  st_d.prdata = {st_q.dropCount, st_q.accCount};
          eccf_pkg::REG_LAST:   st_d.prdata = st_q.last;
          default:              st_d.prdata = '0;
        endcase
      end
    end
    wrDone = psel && penable && st_q.pready && pwrite;
    if (wrDone && paddr == eccf_pkg::REG_CTRL) begin
      st_d.ctrlEn  = pwdata[eccf_pkg::CTRL_EN_BIT];
      st_d.ctrlRxo = pwdata[eccf_pkg::CTRL_RXO_BIT];
      st_d.maxHops = pwdata[eccf_pkg::CTRL_HOPS_LSB +: 8];
    end
    if (wrDone && paddr == eccf_pkg::REG_STATUS) begin
      errClr = eccf_pkg::eccf_err_t'(pwdata[6:0]);
    end
    // Set beats clear on the same cycle
    st_d.status  = (st_q.status & ~errClr) | errSet;
    st_d.rxReady = st_d.ctrlEn && (st_d.phase != eccf_pkg::P_EMIT);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.phase   <= eccf_pkg::P_HUNT;
      st_q.ctrlEn  <= eccf_pkg::CTRL_EN_RST;
      st_q.ctrlRxo <= eccf_pkg::CTRL_RXO_RST;
      st_q.maxHops <= MAX_HOPS_DEFAULT;
    end else begin
      st_q <= st_d;
    end
  end

  eccf_skid_buf #(
    .WIDTH ($bits(eccf_pkg::eccf_cmd_t)),
    .DEPTH (2)
  ) uBuf (
    .clock    (clock),
    .rst_n    (rst_n),
    .inValid  (st_q.phase == eccf_pkg::P_EMIT),
    .inReady  (bufInReady),
    .inData   (st_q.rec),
    .outValid (cmdValid),
    .outReady (cmdReady),
    .outData  (cmd)
  );

  assign prdata         = st_q.prdata;
  assign pready         = st_q.pready;
  assign pslverr        = st_q.pslverr;
  assign rxReady        = st_q.rxReady;
  assign txStatusValid  = st_q.txStatusValid;
  assign txStatusId     = st_q.txStatusId;
  assign explicitRxMode = st_q.ctrlRxo;

endmodule : eccf_framer
`default_nettype wire

/* File: inc/eccf_pkg.sv */
/*
  Constants, field layouts and carrier types of the explicit cluster command framer.
  Assumes a single 40 MHz clock domain and APB access with 32-bit data.
*/
// Summary of operation
// - Offset 23 holds frame-control bitfield
// - Offset 24 sequence number, echoed by response
// - Offset 25 command ID; 0x00 reads attributes
// - Checksum is 0xFF minus byte sum
// - Frame-control bits 0-1 give frame type
// - Bit 2 clear means no manufacturer code
// - Bit 3 gives command direction
// - Bit 4 disables default response; 5-7 zero
// - Option bit selects explicit receive frames
// - Zero frame ID suppresses transmit status
// - Zero radius means network maximum hops
package eccf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  DELIM         = 8'h7e;
  localparam logic [7:0]  FT_EXPLICIT   = 8'h11;
  localparam logic [15:0] OFF_LEN_LSB   = 16'h0002;
  localparam logic [15:0] OFF_FTYPE     = 16'h0003;
  localparam logic [15:0] OFF_FID       = 16'h0004;
  localparam logic [15:0] OFF_ADDR64    = 16'h0005;
  localparam logic [15:0] OFF_ADDR64_LS = 16'h000c;
  localparam logic [15:0] OFF_ADDR16    = 16'h000d;
  localparam logic [15:0] OFF_ADDR16_LS = 16'h000e;
  localparam logic [15:0] OFF_SRCEP     = 16'h000f;
  localparam logic [15:0] OFF_DSTEP     = 16'h0010;
  localparam logic [15:0] OFF_CLUSTER   = 16'h0011;
  localparam logic [15:0] OFF_PROFILE   = 16'h0013;
  localparam logic [15:0] OFF_RADIUS    = 16'h0015;
  localparam logic [15:0] OFF_TXOPT     = 16'h0016;
  localparam logic [15:0] OFF_FCTRL     = 16'h0017;
  localparam logic [15:0] OFF_SEQ       = 16'h0018;
  localparam logic [15:0] OFF_CMDID     = 16'h0019;
  localparam logic [15:0] OFF_PAYLOAD   = 16'h001a;
  localparam logic [15:0] LEN_BIAS      = 16'h0002;
  localparam logic [15:0] MIN_LEN       = 16'h0017;
  localparam logic [7:0]  CSUM_BASE     = 8'hff;
  localparam logic [63:0] BCAST64       = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] BCAST16       = 16'hfffe;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          FC_TYPE_LSB   = 0;
  localparam int          FC_MFR_BIT    = 2;
  localparam int          FC_DIR_BIT    = 3;
  localparam int          FC_NODFLT_BIT = 4;
  localparam int          FC_RSVD_LSB   = 5;
  localparam logic [1:0]  FTYPE_GENERAL = 2'h0;
  localparam logic [7:0]  CMD_READ_ATTR = 8'h00;
  localparam int          ATTR_MAX      = 4;
  localparam int          ATTR_CNT_W    = 3;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_STATUS    = 12'h004;
  localparam logic [11:0] REG_COUNT     = 12'h008;
  localparam logic [11:0] REG_LAST      = 12'h00c;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_RXO_BIT  = 1;
  localparam int          CTRL_HOPS_LSB = 8;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic        CTRL_RXO_RST  = 1'b0;
  localparam logic [7:0]  MAXHOPS_RST   = 8'h0f;

  typedef enum logic [4:0] {
    P_HUNT = 5'b00001,
    P_LEN  = 5'b00010,
    P_BODY = 5'b00100,
    P_CSUM = 5'b01000,
    P_EMIT = 5'b10000
  } eccf_phase_t;

  typedef struct packed {
    logic attrOvf;
    logic oddPay;
    logic shortLen;
    logic csumBad;
    logic rsvdNz;
    logic txOptNz;
    logic badType;
  } eccf_err_t;

  typedef struct packed {
    logic [7:0]                    frameId;
    logic [63:0]                   dest64;
    logic [15:0]                   dest16;
    logic [7:0]                    srcEp;
    logic [7:0]                    dstEp;
    logic [15:0]                   clusterId;
    logic [15:0]                   profileId;
    logic [7:0]                    radius;
    logic [7:0]                    frameCtrl;
    logic [7:0]                    seqNum;
    logic [7:0]                    cmdId;
    logic [15:0]                   mfrCode;
    logic [ATTR_CNT_W-1:0]         attrCount;
    logic [ATTR_MAX-1:0][15:0]     attrs;
    logic                          broadcast;
    logic                          readAttr;
  } eccf_cmd_t;

endpackage : eccf_pkg

/* File: design/eccf_skid_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides; outputs come from flops.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module eccf_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  if (WIDTH < 1 || DEPTH != 2) begin : gChk
    $error("eccf_skid_buf serves only DEPTH 2 and WIDTH of at least 1");
  end

  typedef struct packed {
    logic             headV;
    logic [WIDTH-1:0] head;
    logic             spareV;
    logic [WIDTH-1:0] spare;
  } eccf_buf_st_t;

  eccf_buf_st_t st_q;
  eccf_buf_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.headV && outReady) begin
      st_d.headV  = st_q.spareV;
      st_d.head   = st_q.spare;
      st_d.spareV = 1'b0;
    end
    if (inValid && !st_q.spareV) begin
      if (!st_d.headV) begin
        st_d.headV = 1'b1;
        st_d.head  = inData;
      end else begin
        st_d.spareV = 1'b1;
        st_d.spare  = inData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign inReady  = !st_q.spareV;
  assign outValid = st_q.headV;
  assign outData  = st_q.head;

endmodule : eccf_skid_buf
`default_nettype wire

/* File: test/eccf_framer_monitor.sv */
/*
  Port assertions for the explicit cluster command framer.
  Assumes it is bound to eccf_framer and that one clock serves all ports.
*/
`timescale 1ns/1ps
`default_nettype none
module eccf_framer_monitor (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                cmdValid,
  input wire logic                cmdReady,
  input wire eccf_pkg::eccf_cmd_t cmd,
  input wire logic                txStatusValid,
  input wire logic [7:0]          txStatusId
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready && penable ##1 !pready;
  endsequence
  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  property p_apb_err;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  property p_hold;
    cmdValid && !cmdReady |=> cmdValid && $stable(cmd);
  endproperty
  property p_stat_id;
    txStatusValid |-> txStatusId != 8'h00 ##1 !txStatusValid;
  endproperty
  property p_radius;
    cmdValid |-> cmd.radius != 8'h00;
  endproperty
  property p_read;
    cmdValid |-> cmd.readAttr == (cmd.frameCtrl[1:0] == 2'h0 && cmd.cmdId == 8'h00);
  endproperty
  property p_bcast;
    cmdValid |-> cmd.broadcast == (cmd.dest64 == 64'h0000_0000_0000_ffff || cmd.dest16 == 16'hfffe);
  endproperty
  property p_attr;
    cmdValid |-> cmd.attrCount <= 3'h4;
  endproperty

  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle after setup");
  a_apb_err:    assert property (p_apb_err) else $error("slave error without ready or with data");
  a_hold:       assert property (p_hold) else $error("record changed while stalled");
  a_stat_id:    assert property (p_stat_id) else $error("status pulse bad");
  a_radius:     assert property (p_radius) else $error("zero radius handed on");
  a_read:       assert property (p_read) else $error("read flag disagrees with header");
  a_bcast:      assert property (p_bcast) else $error("broadcast flag wrong");
  a_attr:       assert property (p_attr) else $error("too many attributes");
endmodule : eccf_framer_monitor

bind eccf_framer eccf_framer_monitor mon_u (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
  .txStatusValid(txStatusValid), .txStatusId(txStatusId)
);
`default_nettype wire

/* File: test/eccf_host_model.sv */
/*
  Host that streams queued frame bytes with valid and ready.
  Assumes the bench pushes whole frames into q; slow inserts idle cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module eccf_host_model (
  input wire logic  clock,
  input wire logic  rst_n,
  input wire logic  slow,
  input wire logic  rxReady,
  output var logic  rxValid,
  output var logic [7:0] rxByte
);
  logic [7:0] q[$];
  logic       gap;

  initial rxByte = 8'h00;
  // Byte held until taken; idle line shows a changing pattern
  always @(posedge clock) begin
    if (!rst_n) begin
      rxValid <= 1'b0;
      rxByte  <= 8'h00;
      gap     <= 1'b0;
    end else if (!rxValid || rxReady) begin
      gap <= slow && !gap;
      if (q.size() > 0 && !gap) begin
        rxByte  <= q.pop_front();
        rxValid <= 1'b1;
      end else begin
        rxValid <= 1'b0;
        rxByte  <= ~rxByte;
      end
    end
  end
endmodule : eccf_host_model
`default_nettype wire

/* File: test/eccf_framer_tb.sv */
/*
  Self-checking bench for the framer: APB register tasks and host frames.
  Assumes the host model and the bound port monitor.
*/
`timescale 1ns/1ps
`default_nettype none
module eccf_framer_tb;
  logic                clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                rxValid, rxReady, cmdValid, cmdReady, txStatusValid, explicitRxMode, slow, err;
  logic [7:0]          rxByte, txStatusId;
  eccf_pkg::eccf_cmd_t cmd;
  eccf_pkg::eccf_cmd_t got[$];
  logic [7:0]          ids[$];
  int                  error_cnt, n_compared, cycles;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  eccf_framer dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxByte(rxByte),
    .rxValid(rxValid), .rxReady(rxReady), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .txStatusValid(txStatusValid), .txStatusId(txStatusId), .explicitRxMode(explicitRxMode));
  eccf_host_model host_u (.clock(clock), .rst_n(rst_n), .slow(slow), .rxReady(rxReady),
    .rxValid(rxValid), .rxByte(rxByte));

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cmdValid && cmdReady) got.push_back(cmd);
    if (txStatusValid) ids.push_back(txStatusId);
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rchk(string n, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(n, rd, e);
  endtask : rchk

  // Frame body from offset 3, then delimiter, length and checksum around it
  task automatic send(logic [7:0] fid, ft, txo, fc, seq, np, rad, logic [15:0] d16, logic bad);
    logic [7:0]  b[$];
    logic [7:0]  s;
    logic [63:0] d64;
    d64 = 64'h0013_a200_4040_1234;
    b = {ft, fid};
    for (int i = 7; i >= 0; i--) b.push_back(d64[8*i +: 8]);
    b = {b, d16[15:8], d16[7:0], 8'h41, 8'h42, 8'h00, 8'h00, 8'hd1, 8'h23, rad, txo, fc, seq, 8'h00};
    for (int k = 0; k < np; k++) b.push_back(k[0] ? 8'(k / 2) : 8'(8'h03 + k / 2));
    s = 8'h00;
    foreach (b[i]) s += b[i];
    host_u.q = {host_u.q, 8'h7e, 8'h00, 8'(b.size()), b, (8'hff - s) ^ {7'h00, bad}};
  endtask : send

  task automatic chk_cmd(int i, logic [7:0] fid, fc, seq, rad, logic [2:0] n, logic [15:0] d16, logic bc, ra);
    eccf_pkg::eccf_cmd_t c;
    c = got[i];
    check("frameId", c.frameId, fid);
    check("dest64", c.dest64, 64'h0013_a200_4040_1234);
    check("dest16", c.dest16, d16);
    check("ends", {c.srcEp, c.dstEp, c.clusterId, c.profileId}, 48'h4142_0000_d123);
    check("radius", c.radius, rad);
    check("hdr", {c.frameCtrl, c.seqNum, c.cmdId}, {fc, seq, 8'h00});
    check("attrCount", c.attrCount, n);
    for (int k = 0; k < n; k++) check("attr", c.attrs[k], {8'(k), 8'(8'h03 + k)});
    check("flags", {c.broadcast, c.readAttr}, {bc, ra});
  endtask : chk_cmd

  task automatic wait_cmds(int n);
    for (int i = 0; i < 3000 && got.size() < n; i++) @(posedge clock);
    check("cmds", got.size() >= n, 1'b1);
  endtask : wait_cmds

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmdReady = 1'b1;
    rst_n = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk("ctrl", eccf_pkg::REG_CTRL, 32'h0000_0f01);
    rchk("status", eccf_pkg::REG_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped", {err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000);
    apb(1'b1, eccf_pkg::REG_CTRL, 32'h0000_0f03);
    apb(1'b1, eccf_pkg::REG_COUNT, 32'hffff_ffff);
    @(posedge clock);
    check("rxMode", explicitRxMode, 1'b1);
    send(8'h01, 8'h11, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 16'hfffe, 1'b0);
    wait_cmds(1);
    chk_cmd(0, 8'h01, 8'h00, 8'h01, 8'h0f, 3'h1, 16'hfffe, 1'b1, 1'b1);
    send(8'h00, 8'h11, 8'h00, 8'h18, 8'h02, 8'h08, 8'h05, 16'h5678, 1'b0);
    wait_cmds(2);
    chk_cmd(1, 8'h00, 8'h18, 8'h02, 8'h05, 3'h4, 16'h5678, 1'b0, 1'b1);
    check("status ids", {ids.size(), ids[0]}, {32'h1, 8'h01});
    send(8'h01, 8'h10, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 16'hfffe, 1'b0);
    send(8'h01, 8'h11, 8'h00, 8'h00, 8'h05, 8'h02, 8'h00, 16'hfffe, 1'b1);
    host_u.q = {host_u.q, 8'h7e, 8'h00, 8'h05, 8'h11, 8'h01, 8'h02, 8'h03, 8'h04, 8'h55};
    send(8'h03, 8'h11, 8'h01, 8'he0, 8'h03, 8'h0b, 8'h07, 16'hfffe, 1'b0);
    wait_cmds(3);
    chk_cmd(2, 8'h03, 8'he0, 8'h03, 8'h07, 3'h4, 16'hfffe, 1'b1, 1'b1);
    rchk("status", eccf_pkg::REG_STATUS, 32'h0000_007f);
    apb(1'b1, eccf_pkg::REG_STATUS, 32'h0000_007f);
    rchk("status clr", eccf_pkg::REG_STATUS, 32'h0000_0000);
    rchk("count", eccf_pkg::REG_COUNT, 32'h0003_0003);
    cmdReady <= 1'b0;
    slow <= 1'b1;
    for (int k = 0; k < 3; k++) send(8'(8'h10 + k), 8'h11, 8'h00, 8'h01, 8'(8'h10 + k), 8'h00, 8'h02, 16'hfffe, 1'b0);
    for (int i = 0; i < 3000 && host_u.q.size() > 0; i++) @(posedge clock);
    repeat (20) @(posedge clock);
    check("stall", {got.size(), rxReady, cmdValid}, {32'h3, 1'b0, 1'b1});
    cmdReady <= 1'b1;
    wait_cmds(6);
    for (int k = 0; k < 3; k++) chk_cmd(3 + k, 8'(8'h10 + k), 8'h01, 8'(8'h10 + k), 8'h02, 3'h0, 16'hfffe, 1'b1, 1'b0);
    check("status n", ids.size(), 5);
    give_verdict();
  end
endmodule : eccf_framer_tb
`default_nettype wire
